// >>> dlc_board.sv
`timescale 1ns/100ps

module dlc_board
   import dlc_pkg::*;
#(
   parameter int HALF = 8, // source half period in core cycles
   parameter int DLY  = 6  // board trace delay in core cycles
)(
   // core clock and bench controls
   input  wire logic      core_clk,
   input  wire logic      src_run,
   input  wire logic      fb_run,
   input  wire logic      fb_from_dbl,
   // loop outputs reaching the board
   input  wire logic      mirror_clock_out,
   input  wire dlc_clks_s loop_clks,
   // pins back into the loop
   output logic           source_clock_in,
   output logic           feedback_clock_in
);
   int          ph_cnt = 0;
   logic [31:0] trace  = 32'h0;

   // pins start low so the loop never sees an unknown edge
   initial source_clock_in = 1'b0;
   initial feedback_clock_in = 1'b0;

   // free-running 50/50 source while enabled, stands low when stopped
   always @(posedge core_clk) begin
      if (!src_run) begin
         ph_cnt <= 0;
         source_clock_in <= 1'b0;
      end else if (ph_cnt == HALF - 1) begin
         ph_cnt <= 0;
         source_clock_in <= ~source_clock_in;
      end else begin
         ph_cnt <= ph_cnt + 1;
      end
   end

   // only zero-phase or doubled output returns; synchroniser plus trace delay must exceed half a period to lock
   always @(posedge core_clk) begin
      trace <= {trace[30:0], fb_from_dbl ? loop_clks.dbl : mirror_clock_out};
      feedback_clock_in <= fb_run & trace[DLY-1];
   end
endmodule

// >>> dlc_defs.svh
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH

// delay line and period measurement widths
`define DLC_IDX_W      7
`define DLC_HIST_W     128
`define DLC_IDX_MAX    7'h7f
`define DLC_TAP_RST    7'h00

// lock detector
`define DLC_LOCK_CNT   4'h8
`define DLC_ALIGN_TOL  7'h01

// divider ratio codes and twice the ratio for each
`define DLC_DIV_SEL_W  3
`define DLC_DIVX2_1P5  6'h03
`define DLC_DIVX2_2    6'h04
`define DLC_DIVX2_2P5  6'h05
`define DLC_DIVX2_3    6'h06
`define DLC_DIVX2_4    6'h08
`define DLC_DIVX2_5    6'h0a
`define DLC_DIVX2_8    6'h10
`define DLC_DIVX2_16   6'h20
`define DLC_DIV_CNT_W  11

// loop network source codes
`define DLC_NET_C0     3'h0
`define DLC_NET_C90    3'h1
`define DLC_NET_C180   3'h2
`define DLC_NET_C270   3'h3
`define DLC_NET_DBL    3'h4
`define DLC_NET_DIV    3'h5

`endif

// >>> dlc_div.sv
`timescale 1ns/100ps
`include "dlc_defs.svh"

module dlc_div
   import dlc_pkg::*;
(
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   input  wire logic                      clr,
   // ratio and measured source period
   input  wire logic [`DLC_DIV_SEL_W-1:0] div_sel,
   input  wire logic [`DLC_IDX_W-1:0]     period,
   // divided clock
   output logic                           div_out
);

   dlc_div_s s_r;
   dlc_div_s s_nxt;
   logic [`DLC_DIV_CNT_W-1:0] half;

   // twice the ratio, so the half ratios stay integer
   function automatic logic [5:0] dlc_divx2(input logic [`DLC_DIV_SEL_W-1:0] sel);
      case (sel)
         3'h0:    dlc_divx2 = `DLC_DIVX2_1P5;
         3'h1:    dlc_divx2 = `DLC_DIVX2_2;
         3'h2:    dlc_divx2 = `DLC_DIVX2_2P5;
         3'h3:    dlc_divx2 = `DLC_DIVX2_3;
         3'h4:    dlc_divx2 = `DLC_DIVX2_4;
         3'h5:    dlc_divx2 = `DLC_DIVX2_5;
         3'h6:    dlc_divx2 = `DLC_DIVX2_8;
         default: dlc_divx2 = `DLC_DIVX2_16;
      endcase
   endfunction

   // half output period in core cycles: ratio * period / 2, 50/50 duty
   always_comb begin
      logic [12:0] prod;
      prod = {7'h00, dlc_divx2(div_sel)} * {6'h00, period}; // widen first, no lost product bits
      half = prod[12:2];
      s_nxt = s_r;
      if (clr) begin
         s_nxt = '0;
      end else if (s_r.cnt + 11'h001 >= half) begin
         s_nxt.cnt = '0;
         s_nxt.out = ~s_r.out;
      end else begin
         s_nxt.cnt = s_r.cnt + 11'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign div_out = s_r.out;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_div_toggle: assert property (
      !$past(clr) && $changed(s_r.out) |-> $past(s_r.cnt) + 11'h001 >= $past(half))
      else $error("divided clock toggled before its half period");
endmodule

// >>> dlc_pkg.sv
`include "dlc_defs.svh"

package dlc_pkg;

   typedef enum logic [1:0] {DLC_RESET, DLC_ACQUIRE, DLC_LOCKED} dlc_state_e;

   // the six loop clock outputs
   typedef struct packed {
      logic c0;
      logic c90;
      logic c180;
      logic c270;
      logic dbl;
      logic div;
   } dlc_clks_s;

   // divider state
   typedef struct packed {
      logic [`DLC_DIV_CNT_W-1:0] cnt;
      logic                      out;
   } dlc_div_s;

   // loop state
   typedef struct packed {
      logic                    src_s1;
      logic                    src_s2;
      logic                    src_d;
      logic                    fb_s1;
      logic                    fb_s2;
      logic                    fb_d;
      logic                    rst_s1;
      logic                    rst_s2;
      logic [3:0]              pad_s1;
      logic [3:0]              pad_s2;
      logic [3:0]              rt_s1;
      logic [3:0]              rt_s2;
      logic [`DLC_HIST_W-1:0]  hist;
      logic [`DLC_IDX_W-1:0]   per_cnt;
      logic [`DLC_IDX_W-1:0]   period;
      logic [`DLC_IDX_W-1:0]   since;
      logic [`DLC_IDX_W-1:0]   tap;
      logic [3:0]              good_cnt;
      dlc_state_e              state;
      logic                    locked;
      dlc_clks_s               clks;
      logic [3:0]              gnet;
      logic [1:0]              lnet;
      logic                    cfg_done;
   } dlc_top_s;

endpackage

// >>> dlc_top.sv
`timescale 1ns/100ps
`include "dlc_defs.svh"

module dlc_top
   import dlc_pkg::*;
(
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   // loop pins
   input  wire logic                      source_clock_in,
   input  wire logic                      feedback_clock_in,
   input  wire logic                      loop_rst,
   // loop setup
   input  wire logic                      feedback_is_doubled,
   input  wire logic [`DLC_DIV_SEL_W-1:0] div_sel,
   input  wire logic [2:0]                net_sel_a,
   input  wire logic [2:0]                net_sel_b,
   // global buffers
   input  wire logic [3:0]                pad_clk,
   input  wire logic [3:0]                route_clk,
   input  wire logic [3:0]                buf_sel_route,
   output logic [3:0]                     global_net,
   // loop outputs
   output dlc_clks_s                      loop_clks,
   output logic [1:0]                     loop_net,
   output logic                           mirror_clock_out,
   output logic                           locked,
   output logic [`DLC_IDX_W-1:0]          tap_value,
   // configuration hold-off
   input  wire logic                      cfg_wait_lock,
   input  wire logic                      cfg_done_req,
   output logic                           cfg_done
);

   dlc_top_s s_r;
   dlc_top_s s_nxt;
   logic     div_clk;
   logic     src_rise;
   logic     fb_rise;

   // rising edge of a synchronised level
   function automatic logic dlc_rise(input logic now, input logic was);
      dlc_rise = now & ~was;
   endfunction

   // delay line index, saturating at the far end
   function automatic logic [`DLC_IDX_W-1:0] dlc_idx(input logic [`DLC_IDX_W-1:0] a,
                                                     input logic [`DLC_IDX_W-1:0] b);
      logic [`DLC_IDX_W:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      dlc_idx = sum[`DLC_IDX_W] ? `DLC_IDX_MAX : sum[`DLC_IDX_W-1:0];
   endfunction

   // one of the six loop clocks for a loop network
   function automatic logic dlc_pick(input dlc_clks_s c, input logic [2:0] sel);
      case (sel)
         `DLC_NET_C0:   dlc_pick = c.c0;
         `DLC_NET_C90:  dlc_pick = c.c90;
         `DLC_NET_C180: dlc_pick = c.c180;
         `DLC_NET_C270: dlc_pick = c.c270;
         `DLC_NET_DBL:  dlc_pick = c.dbl;
         default:       dlc_pick = c.div;
      endcase
   endfunction

   assign src_rise = dlc_rise(s_r.src_s2, s_r.src_d);
   assign fb_rise  = dlc_rise(s_r.fb_s2, s_r.fb_d);

   // divider restarts with the loop so it never runs from a stale period
   dlc_div u_div (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .clr      (s_r.rst_s2),
      .div_sel  (div_sel),
      .period   (s_r.period),
      .div_out  (div_clk)
   );

   // next state of the whole loop
   always_comb begin
      logic [`DLC_IDX_W-1:0] err;
      logic [`DLC_IDX_W-1:0] q;
      logic [`DLC_IDX_W-1:0] h;
      logic                  aligned;
      logic                  second_edge;
      err = src_rise ? 7'h00 : s_r.since;
      q = {2'h0, s_r.period[6:2]};
      h = {1'h0, s_r.period[6:1]};
      aligned = (err <= `DLC_ALIGN_TOL) || (err + `DLC_ALIGN_TOL >= s_r.period);
      // doubled feedback also rises mid period; that edge carries no phase error
      second_edge = feedback_is_doubled && s_r.locked && (err >= q)
                    && (err < s_r.period - q);
      s_nxt = s_r;

      // pin synchronisers, two flops each
      s_nxt.src_s1 = source_clock_in;
      s_nxt.src_s2 = s_r.src_s1;
      s_nxt.src_d  = s_r.src_s2;
      s_nxt.fb_s1  = feedback_clock_in;
      s_nxt.fb_s2  = s_r.fb_s1;
      s_nxt.fb_d   = s_r.fb_s2;
      s_nxt.rst_s1 = loop_rst;
      s_nxt.rst_s2 = s_r.rst_s1;
      s_nxt.pad_s1 = pad_clk;
      s_nxt.pad_s2 = s_r.pad_s1;
      s_nxt.rt_s1  = route_clk;
      s_nxt.rt_s2  = s_r.rt_s1;

      // delay line history, newest sample at index zero
      s_nxt.hist = {s_r.hist[`DLC_HIST_W-2:0], s_r.src_s2};

      // source period and time since the last source edge
      if (src_rise) begin
         s_nxt.period  = s_r.per_cnt;
         s_nxt.per_cnt = 7'h01;
         s_nxt.since   = 7'h01;
      end else begin
         s_nxt.per_cnt = dlc_idx(s_r.per_cnt, 7'h01);
         s_nxt.since   = dlc_idx(s_r.since, 7'h01);
      end

      // tap control and lock detector
      case (s_r.state)
         DLC_RESET: begin
            s_nxt.tap      = `DLC_TAP_RST;
            s_nxt.good_cnt = 4'h0;
            s_nxt.locked   = 1'b0;
            s_nxt.state    = DLC_ACQUIRE;
         end
         DLC_ACQUIRE, DLC_LOCKED: begin
            if (fb_rise && !second_edge) begin
               if (aligned) begin
                  if (s_r.good_cnt == `DLC_LOCK_CNT - 4'h1) begin
                     s_nxt.state  = DLC_LOCKED;
                     s_nxt.locked = 1'b1;
                  end else begin
                     s_nxt.good_cnt = s_r.good_cnt + 4'h1;
                  end
               end else begin
                  // late feedback wants less delay, early wants more
                  s_nxt.good_cnt = 4'h0;
                  s_nxt.locked   = 1'b0;
                  s_nxt.state    = DLC_ACQUIRE;
                  if (err <= h) begin
                     s_nxt.tap = (s_r.tap != 7'h00) ? s_r.tap - 7'h01 : s_r.tap;
                  end else begin
                     s_nxt.tap = dlc_idx(s_r.tap, 7'h01);
                  end
               end
            end
         end
         default: begin
            s_nxt.state = DLC_RESET;
         end
      endcase

      // quadrature phases taken a quarter period apart down the line
      s_nxt.clks.c0   = s_r.hist[s_r.tap];
      s_nxt.clks.c90  = s_r.hist[dlc_idx(s_r.tap, q)];
      s_nxt.clks.c180 = s_r.hist[dlc_idx(s_r.tap, h)];
      s_nxt.clks.c270 = s_r.hist[dlc_idx(s_r.tap, dlc_idx(q, h))];
      // pre-lock 25/75 lets the loop lock on the right edge
      s_nxt.clks.dbl  = s_r.locked ? (s_r.clks.c0 ^ s_r.clks.c90)
                                   : (s_r.clks.c0 & ~s_r.clks.c90);
      s_nxt.clks.div  = div_clk;

      // global buffers and the two loop networks
      s_nxt.gnet = (buf_sel_route & s_r.rt_s2) | (~buf_sel_route & s_r.pad_s2);
      s_nxt.lnet = {dlc_pick(s_r.clks, net_sel_b), dlc_pick(s_r.clks, net_sel_a)};

      // configuration completion held until lock when asked
      s_nxt.cfg_done = cfg_done_req && (!cfg_wait_lock || s_r.locked);

      // loop reset wins over everything else in the loop
      if (s_r.rst_s2) begin
         s_nxt.state    = DLC_RESET;
         s_nxt.tap      = `DLC_TAP_RST;
         s_nxt.good_cnt = 4'h0;
         s_nxt.locked   = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state flops
   assign global_net       = s_r.gnet;
   assign loop_clks        = s_r.clks;
   assign loop_net         = s_r.lnet;
   assign mirror_clock_out = s_r.clks.c0;
   assign locked           = s_r.locked;
   assign tap_value        = s_r.tap;
   assign cfg_done         = s_r.cfg_done;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_reset_taps_zero: assert property (
      s_r.rst_s2 |=> !s_r.locked && s_r.tap == 7'h00)
      else $error("loop reset did not clear lock and taps");

   chk_lock_needs_align: assert property (
      $rose(s_r.locked) |-> $past(fb_rise) && $past(s_r.good_cnt) == `DLC_LOCK_CNT - 4'h1)
      else $error("lock rose without a full run of aligned edges");

   chk_tap_moves_on_fb: assert property (
      !$stable(s_r.tap) |-> $past(fb_rise) || $past(s_r.rst_s2) || $past(s_r.state) == DLC_RESET)
      else $error("tap moved without a feedback compare");

   chk_cfg_hold_lock: assert property (
      cfg_done |-> $past(cfg_done_req) && (!$past(cfg_wait_lock) || $past(s_r.locked)))
      else $error("configuration completed before lock");

   chk_dbl_prelock: assert property (
      !$past(s_r.locked) |-> s_r.clks.dbl == ($past(s_r.clks.c0) & ~$past(s_r.clks.c90)))
      else $error("doubled clock not 25/75 before lock");

   chk_dbl_locked: assert property (
      $past(s_r.locked) |-> s_r.clks.dbl == ($past(s_r.clks.c0) ^ $past(s_r.clks.c90)))
      else $error("doubled clock not 2x after lock");

   chk_gbuf_select: assert property (
      global_net == (($past(buf_sel_route) & $past(s_r.rt_s2))
                   | (~$past(buf_sel_route) & $past(s_r.pad_s2))))
      else $error("global buffer picked the wrong input");

   chk_net_select: assert property (
      $past(net_sel_a) == `DLC_NET_C0 |-> loop_net[0] == $past(s_r.clks.c0))
      else $error("loop network a not driven from zero phase");

   chk_zero_phase_tap: assert property (
      s_r.clks.c0 == $past(s_r.hist[s_r.tap]))
      else $error("zero phase not taken from the active tap");
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
`include "dlc_defs.svh"

module testbench
   import dlc_pkg::*;
   ;
   localparam int P = 16; // source period in core cycles, short to keep the run brief

   logic       core_clk = 1'b0, rst_b = 1'b0, loop_rst = 1'b0, fb_is_dbl = 1'b0;
   logic       cfg_wait = 1'b0, cfg_req = 1'b0, src_run = 1'b0, fb_run = 1'b0;
   logic       fb_from_dbl = 1'b0, src_pin, fb_pin, prev_src = 1'b0, prev_fb = 1'b0;
   logic       mirror, locked, cfg_done;
   logic [2:0] div_sel = 3'h0, net_a = 3'h0, net_b = 3'h0;
   logic [3:0] pad = 4'h0, route = 4'h0, bsel = 4'h0, gnet;
   logic [1:0] lnet;
   logic [6:0] tap;
   dlc_clks_s  clks, prev = '0;
   int         err_count = 0, n_tests = 0, cyc = 0;

   dlc_top uut (
      .core_clk(core_clk), .rst_b(rst_b), .source_clock_in(src_pin),
      .feedback_clock_in(fb_pin), .loop_rst(loop_rst), .feedback_is_doubled(fb_is_dbl),
      .div_sel(div_sel), .net_sel_a(net_a), .net_sel_b(net_b), .pad_clk(pad),
      .route_clk(route), .buf_sel_route(bsel), .global_net(gnet), .loop_clks(clks),
      .loop_net(lnet), .mirror_clock_out(mirror), .locked(locked), .tap_value(tap),
      .cfg_wait_lock(cfg_wait), .cfg_done_req(cfg_req), .cfg_done(cfg_done));

   dlc_board #(.HALF(P / 2), .DLY(6)) far (
      .core_clk(core_clk), .src_run(src_run), .fb_run(fb_run), .fb_from_dbl(fb_from_dbl),
      .mirror_clock_out(mirror), .loop_clks(clks), .source_clock_in(src_pin),
      .feedback_clock_in(fb_pin));

   // 100 MHz core clock
   always #5 core_clk = ~core_clk;

   // one-cycle-old copies for edge detection, plus a cycle stamp
   always @(posedge core_clk) begin
      prev <= clks;
      prev_src <= src_pin;
      prev_fb <= fb_pin;
      cyc <= cyc + 1;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (err_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // land just after the edge so registered outputs have settled
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   function automatic logic pick(input dlc_clks_s c, input logic [2:0] s);
      case (s)
         `DLC_NET_C0:   return c.c0;
         `DLC_NET_C90:  return c.c90;
         `DLC_NET_C180: return c.c180;
         `DLC_NET_C270: return c.c270;
         `DLC_NET_DBL:  return c.dbl;
         default:       return c.div;
      endcase
   endfunction

   task automatic wait_lock();
      #1; // never read lock in the time step of the edge that updates it
      for (int n = 0; n < 3000 && locked !== 1'b1; n++) step(1);
      check("lock reached", locked, 1'b1);
   endtask

   // counts over four whole source periods, so the window start does not matter
   task automatic duty(input logic [31:0] hi_x, input logic [31:0] rise_x);
      int hi, rs;
      hi = 0;
      rs = 0;
      repeat (4 * P) begin
         step(1);
         hi += clks.dbl;
         rs += clks.dbl & ~prev.dbl;
      end
      check("doubled high cycles", hi, hi_x);
      check("doubled rises", rs, rise_x);
   endtask

   task automatic t_global();
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk);
         pad <= i ? 4'ha : 4'h6;
         route <= i ? 4'h3 : 4'h9;
         bsel <= i ? 4'h5 : 4'hc;
         step(5);
         check("global nets", gnet, (bsel & route) | (~bsel & pad));
      end
   endtask

   task automatic t_unlocked();
      duty(P, 4);
      check("locked without feedback", locked, 1'b0);
      @(posedge core_clk);
      cfg_req <= 1'b1;
      cfg_wait <= 1'b1;
      step(3);
      check("config held", cfg_done, 1'b0);
      @(posedge core_clk);
      cfg_wait <= 1'b0;
      step(2);
      check("config without wait", cfg_done, 1'b1);
      @(posedge core_clk);
      cfg_wait <= 1'b1;
   endtask

   task automatic t_lock();
      int ts, d;
      @(posedge core_clk);
      fb_run <= 1'b1;
      wait_lock();
      step(1);
      check("config after lock", cfg_done, 1'b1);
      for (int n = 0; n < 2 * P && !(src_pin && !prev_src); n++) step(1);
      ts = cyc;
      for (int n = 0; n < 2 * P && !(fb_pin && !prev_fb); n++) step(1);
      d = cyc - ts;
      check("feedback to pad skew", d <= 2 || d >= P - 2, 1'b1);
      d = 0;
      repeat (10 * P) begin
         step(1);
         d += (locked !== 1'b1);
      end
      check("lock held", d, 0);
   endtask

   task automatic t_phases();
      int t0, s1, s2, s3;
      duty(2 * P, 8);
      for (int n = 0; n < 2 * P && !(clks.c0 && !prev.c0); n++) step(1);
      t0 = cyc;
      repeat (P) begin
         step(1);
         if (clks.c90 && !prev.c90) s1 = cyc - t0;
         if (clks.c180 && !prev.c180) s2 = cyc - t0;
         if (clks.c270 && !prev.c270) s3 = cyc - t0;
      end
      check("c90 lag", s1, P / 4);
      check("c180 lag", s2, P / 2);
      check("c270 lag", s3, 3 * P / 4);
   endtask

   task automatic t_net();
      for (int s = 0; s < 8; s++) begin
         @(posedge core_clk);
         net_a <= 3'(s);
         net_b <= 3'(7 - s);
         step(2);
         repeat (P) begin
            step(1);
            check("loop net a", lnet[0], pick(prev, net_a));
            check("loop net b", lnet[1], pick(prev, net_b));
            check("mirror output", mirror, clks.c0);
         end
      end
   endtask

   // half period of the divided clock is ratio times the source period over two
   task automatic t_div();
      logic [5:0] x2 [8];
      int tl;
      x2 = '{`DLC_DIVX2_1P5, `DLC_DIVX2_2, `DLC_DIVX2_2P5, `DLC_DIVX2_3,
             `DLC_DIVX2_4, `DLC_DIVX2_5, `DLC_DIVX2_8, `DLC_DIVX2_16};
      for (int k = 0; k < 8; k++) begin
         @(posedge core_clk);
         div_sel <= 3'(k);
         for (int e = 0; e < 4; e++) begin
            step(1);
            for (int n = 0; n < 300 && clks.div === prev.div; n++) step(1);
            if (e == 3) check("divided half period", cyc - tl, x2[k] * P / 4);
            tl = cyc;
         end
      end
   endtask

   task automatic t_rst();
      int n;
      @(posedge core_clk);
      loop_rst <= 1'b1;
      n = 0;
      step(1);
      while (locked !== 1'b0 && n < 8 * P) begin
         step(1);
         n++;
      end
      check("lock drop time", n < 4 * P, 1'b1);
      step(2);
      check("taps cleared", tap, 7'h00);
      check("config dropped", cfg_done, 1'b0);
      @(posedge core_clk);
      loop_rst <= 1'b0;
   endtask

   task automatic t_dbl_fb();
      @(posedge core_clk);
      fb_from_dbl <= 1'b1;
      fb_is_dbl <= 1'b1;
      wait_lock();
      step(4 * P);
      check("lock on doubled feedback", locked, 1'b1);
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      step(1);
      check("outputs after reset", {locked, tap, cfg_done, clks}, 15'h0000);
      t_global();
      @(posedge core_clk);
      src_run <= 1'b1;
      step(6 * P);
      t_unlocked();
      t_lock();
      t_phases();
      t_net();
      t_div();
      t_rst();
      t_dbl_fb();
      tally_and_finish();
   end

   // watchdog: the sequence needs well under ten thousand cycles
   initial begin
      #200000;
      err_count++;
      tally_and_finish();
   end
endmodule
